// >>> src/aec_regs.svh
/*
 * Constants for the conversion result error correction block.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef AEC_REGS_SVH
`define AEC_REGS_SVH

// ============================================================
// Arithmetic
`define AEC_GAIN_SHIFT      15
`define AEC_UNITY_GAIN      16'h8000

// ============================================================
// Reset values
`define AEC_CH_EN_RST       1'b0
`define AEC_OFFSET_RST      16'h0000

// ============================================================
// Buffering
`define AEC_FIFO_DEPTH      16

`endif

// >>> src/aec_pkg.sv
/*
 * Types shared by the error correction block.
 * Assumes the constants header is on the include path.
 */
`include "aec_regs.svh"

package aec_pkg;

  // ============================================================
  // Pipeline states of the correction datapath
  typedef enum logic [1:0] {
    AEC_IDLE,
    AEC_MULT,
    AEC_PUSH
  } aec_state_t;

endpackage : aec_pkg

// >>> src/aec_stream_if.sv
/*
 * Valid/ready stream carrier between the correction core and its FIFO.
 * Assumes a single clock domain.
 */
`timescale 1ns/1ps

interface aec_stream_if #(
  parameter int W = 32
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src  (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface : aec_stream_if

// >>> src/aec_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps

module aec_fifo #(
  parameter int W = 32,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic  ref_clk_i,
  input  wire logic  arst_n_i,
  // Streams
  aec_stream_if.sink in_s,
  aec_stream_if.src  out_s
);

  localparam int AW = $clog2(D);

  // Pointer wrap relies on a power-of-two depth
  if (D < 2 || (1 << AW) != D)
  begin : g_bad_depth
    $error("aec_fifo: depth must be a power of two of at least 2");
  end

  logic [W-1:0] mem_q [D];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;

  wire          full_w  = (wr_q[AW] != rd_q[AW]) &&
                          (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire          empty_w = (wr_q == rd_q);
  wire          push_w  = in_s.valid && !full_w;
  wire          pop_w   = out_s.ready && !empty_w;

  assign in_s.ready  = !full_w;
  assign out_s.valid = !empty_w;
  assign out_s.data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge ref_clk_i)
  begin
    if (push_w)
      mem_q[wr_q[AW-1:0]] <= in_s.data;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push_w)
        wr_q <= wr_q + 1'b1;
      if (pop_w)
        rd_q <= rd_q + 1'b1;
    end
  end

endmodule : aec_fifo

// >>> src/aec_correct.sv
/*
 * Offset and gain correction of averaged conversion results.
 * Assumes averaged two's-complement results arrive on a valid/ready
 * stream tagged with channel and sample-and-hold unit, on one clock.
 */
// Summary of operation
// - Correct only channels whose enable bit set
// - One offset/gain pair per sample-and-hold unit
// - Unit select routes value reads and writes
// - Offset is signed two's-complement
// - Result = (data + offset) * gain >> 15
// - Correct averaged results, two's-complement data, offset and result, unsigned gain
// - Same correction in every conversion mode
`timescale 1ns/1ps
`include "aec_regs.svh"

module aec_correct
  import aec_pkg::*;
#(
  parameter int DW     = 16,
  parameter int NCH    = 12,
  parameter int NSH    = 2,
  parameter int CHW    = 4,
  parameter int SHW    = 1,
  parameter int FDEPTH = `AEC_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                arst_n_i,
  // Configuration
  input  wire logic [NCH-1:0]      channel_correct_enable_reg_i,
  input  wire logic [SHW-1:0]      correct_unit_select_reg_i,
  input  wire logic                correct_values_wr_i,
  input  wire logic [DW-1:0]       offset_trim_value_i,
  input  wire logic [DW-1:0]       gain_trim_value_i,
  output      logic [DW-1:0]       offset_trim_value_o,
  output      logic [DW-1:0]       gain_trim_value_o,
  // Averaged results in
  input  wire logic                avg_valid_i,
  output      logic                avg_ready_o,
  input  wire logic [DW-1:0]       avg_data_i,
  input  wire logic [CHW-1:0]      avg_chan_i,
  input  wire logic [SHW-1:0]      avg_unit_i,
  // Corrected results out
  output      logic                res_valid_o,
  input  wire logic                res_ready_i,
  output      logic [DW-1:0]       res_data_o,
  output      logic [CHW-1:0]      res_chan_o
);

  localparam int FW = DW + CHW;
  localparam int PW = 2 * DW + 2;

  // Refuse parameter sets the index and sign logic cannot serve
  if (NSH > (1 << SHW) || NCH > (1 << CHW) || DW < 2)
  begin : g_bad_params
    $error("aec_correct: parameter widths cannot hold the counts");
  end

  // ============================================================
  // Arithmetic helpers
  function automatic logic [DW-1:0] sat_fn(input logic [PW-1:0] v);
    logic [PW-1:0] mx;
    logic [PW-1:0] mn;
    mx = PW'({1'b0, {(DW-1){1'b1}}});
    mn = ~mx;
    if (!v[PW-1] && $signed(v) > $signed(mx))
      sat_fn = {1'b0, {(DW-1){1'b1}}};
    else if (v[PW-1] && $signed(v) < $signed(mn))
      sat_fn = {1'b1, {(DW-1){1'b0}}};
    else
      sat_fn = v[DW-1:0];
  endfunction : sat_fn

  // ============================================================
  // Per-unit correction values
  logic [DW-1:0] offset_q [NSH];
  logic [DW-1:0] gain_q   [NSH];

  wire           sel_ok_w = 32'(correct_unit_select_reg_i) < NSH;

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      for (int i = 0; i < NSH; i++)
      begin
        offset_q[i] <= DW'(`AEC_OFFSET_RST);
        gain_q[i]   <= DW'(`AEC_UNITY_GAIN >> (16 - DW + 1));
      end
    end
    else if (correct_values_wr_i && sel_ok_w)
    begin
      // Writes land in the selected unit
      offset_q[correct_unit_select_reg_i] <= offset_trim_value_i;
      gain_q[correct_unit_select_reg_i]   <= gain_trim_value_i;
    end
  end

  // Readback follows the same selection
  wire [DW-1:0] rd_off_w = sel_ok_w ?
                           offset_q[correct_unit_select_reg_i] : '0;
  wire [DW-1:0] rd_gain_w = sel_ok_w ?
                            gain_q[correct_unit_select_reg_i] : '0;

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      offset_trim_value_o <= '0;
      gain_trim_value_o   <= '0;
    end
    else
    begin
      offset_trim_value_o <= rd_off_w;
      gain_trim_value_o   <= rd_gain_w;
    end
  end

  // ============================================================
  // Correction pipeline: sum stage, then multiply stage
  aec_state_t     state_q;
  logic [DW:0]    sum_q;
  logic [DW-1:0]  gain_s_q;
  logic [DW-1:0]  pass_q;
  logic           en_q;
  logic [CHW-1:0] chan_q;
  logic [DW-1:0]  res_q;

  aec_stream_if #(.W(FW)) push_s ();
  aec_stream_if #(.W(FW)) pop_s ();

  // Skip the ready cycle: valid still stands for the beat just consumed
  wire            take_w   = avg_valid_i && (state_q == AEC_IDLE) &&
                             !avg_ready_o;
  wire [SHW-1:0]  unit_w   = 32'(avg_unit_i) < NSH ? avg_unit_i : '0;
  // Channels beyond the enable vector are never corrected
  wire            en_w     = 32'(avg_chan_i) < NCH ?
                             channel_correct_enable_reg_i[avg_chan_i] : 1'b0;
  // Offset and data sign-extended, no mode input is consulted
  wire [DW:0]     sum_w    = {avg_data_i[DW-1], avg_data_i} +
                             {offset_q[unit_w][DW-1], offset_q[unit_w]};
  // Gain treated as unsigned magnitude scaled by 2^15
  wire [PW-1:0]   prod_w   = PW'($signed({{(DW+1){sum_q[DW]}}, sum_q}) *
                                 $signed({1'b0, {(DW+1){1'b0}}, gain_s_q}));
  wire [PW-1:0]   shft_w   = PW'($signed(prod_w) >>> `AEC_GAIN_SHIFT);

  assign push_s.valid = (state_q == AEC_PUSH);
  assign push_s.data  = {chan_q, res_q};

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_q  <= AEC_IDLE;
      sum_q    <= '0;
      gain_s_q <= '0;
      pass_q   <= '0;
      en_q     <= `AEC_CH_EN_RST;
      chan_q   <= '0;
      res_q    <= '0;
    end
    else
    begin
      unique case (state_q)
        AEC_IDLE:
        begin
          if (take_w)
          begin
            sum_q    <= sum_w;
            gain_s_q <= gain_q[unit_w];
            pass_q   <= avg_data_i;
            en_q     <= en_w;
            chan_q   <= avg_chan_i;
            state_q  <= AEC_MULT;
          end
        end
        AEC_MULT:
        begin
          // Saturate rather than wrap on overflow
          res_q   <= en_q ? sat_fn(shft_w) : pass_q;
          state_q <= AEC_PUSH;
        end
        AEC_PUSH:
        begin
          if (push_s.ready)
            state_q <= AEC_IDLE;
        end
      endcase
    end
  end

  // Ready from a flop so the input handshake is registered
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      avg_ready_o <= 1'b0;
    else
      avg_ready_o <= (state_q == AEC_PUSH) && push_s.ready;
  end

  // ============================================================
  // Output buffer and registered output stage
  aec_fifo #(
    .W (FW),
    .D (FDEPTH)
  ) u_fifo (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .in_s      (push_s),
    .out_s     (pop_s)
  );

  wire out_free_w = !res_valid_o || res_ready_i;
  assign pop_s.ready = out_free_w;

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      res_valid_o <= 1'b0;
      res_data_o  <= '0;
      res_chan_o  <= '0;
    end
    else if (out_free_w)
    begin
      res_valid_o <= pop_s.valid;
      if (pop_s.valid)
      begin
        res_data_o <= pop_s.data[DW-1:0];
        res_chan_o <= pop_s.data[FW-1:DW];
      end
    end
  end

endmodule : aec_correct

// >>> testbench/aec_chk.sv
/* Port checker for aec_correct.
   Assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/1ps

module aec_chk #(
  parameter int DW  = 16,
  parameter int NCH = 12,
  parameter int CHW = 4,
  parameter int SHW = 1
) (
  // Clock, reset, configuration
  input wire logic           ref_clk_i,
  input wire logic           arst_n_i,
  input wire logic [SHW-1:0] correct_unit_select_reg_i,
  input wire logic           correct_values_wr_i,
  input wire logic [DW-1:0]  offset_trim_value_o,
  input wire logic [DW-1:0]  gain_trim_value_o,
  // Streams
  input wire logic           avg_valid_i,
  input wire logic           avg_ready_o,
  input wire logic           res_valid_o,
  input wire logic           res_ready_i,
  input wire logic [DW-1:0]  res_data_o,
  input wire logic [CHW-1:0] res_chan_o
);
  // ============================================================
  // Sequences
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence take_s;
    $rose(avg_valid_i);
  endsequence
  sequence quiet_s;
    (!correct_values_wr_i && $stable(correct_unit_select_reg_i)) [*3];
  endsequence

  // ============================================================
  // Assertions
  out_hold_a: assert property (res_valid_o && !res_ready_i |=>
    res_valid_o && $stable(res_data_o) && $stable(res_chan_o))
    else $error("stalled beat changed");
  rdy_pulse_a: assert property (avg_ready_o |=> !avg_ready_o)
    else $error("ready longer than one cycle");
  rdy_late_a: assert property (take_s |->
    !avg_ready_o [*2] ##[1:3] avg_ready_o) else $error("ready late");
  rdy_cause_a: assert property (avg_ready_o |-> avg_valid_i)
    else $error("ready without beat");
  out_soon_a: assert property (avg_ready_o |-> ##[0:2] res_valid_o)
    else $error("result missing");
  val_fall_a: assert property ($fell(res_valid_o) |-> $past(res_ready_i))
    else $error("beat dropped");
  chan_rng_a: assert property (res_valid_o |-> res_chan_o < NCH)
    else $error("channel out of range");
  rb_hold_a: assert property (quiet_s |=> $stable(offset_trim_value_o)
    && $stable(gain_trim_value_o)) else $error("readback moved");
endmodule : aec_chk

bind aec_correct aec_chk #(.DW(DW), .NCH(NCH), .CHW(CHW), .SHW(SHW))
  aec_chk_inst (.*);

// >>> testbench/aec_avg_model.sv
/* Averaging stage model offering averaged results.
   Assumes send is called from one process at a time. */
`timescale 1ns/1ps

module aec_avg_model (
  // Clock and handshake
  input  wire logic        ref_clk_i,
  input  wire logic        avg_ready_o,
  // Beat
  output      logic        avg_valid_i,
  output      logic [15:0] avg_data_i,
  output      logic [3:0]  avg_chan_i,
  output      logic [0:0]  avg_unit_i
);
  initial
  begin
    avg_valid_i = 1'b0;
    avg_data_i  = 16'h0000;
    avg_chan_i  = 4'h0;
    avg_unit_i  = 1'b0;
  end

  // Two's-complement averaged beat, held until taken
  task automatic send(input logic [15:0] d, input logic [3:0] c,
                      input logic u);
    @(posedge ref_clk_i);
    #1;
    avg_valid_i = 1'b1;
    avg_data_i  = d;
    avg_chan_i  = c;
    avg_unit_i  = u;
    do @(posedge ref_clk_i); while (avg_ready_o !== 1'b1);
    #1;
    avg_valid_i = 1'b0;
    // Released data and channel lines must not look like the last beat
    avg_data_i  = ~d;
    avg_chan_i  = ~c;
  endtask : send
endmodule : aec_avg_model

// >>> testbench/testbench.sv
/* Self-checking bench for aec_correct.
   Assumes the averaging model drives the input stream. */
`timescale 1ns/1ps

module testbench;
  logic        ref_clk_i, arst_n_i, correct_values_wr_i, res_ready_i;
  logic        avg_valid_i, avg_ready_o, res_valid_o;
  logic [11:0] channel_correct_enable_reg_i;
  logic [0:0]  correct_unit_select_reg_i, avg_unit_i;
  logic [15:0] offset_trim_value_i, gain_trim_value_i, avg_data_i;
  logic [15:0] offset_trim_value_o, gain_trim_value_o, res_data_o;
  logic [3:0]  avg_chan_i, res_chan_o;
  int          error_cnt, cmp_count, n;
  logic [15:0] td [5] = '{16'h0064, 16'h0064, 16'hff9c, 16'h04d2, 16'h7ff8};
  logic [15:0] te [5] = '{16'h006e, 16'h0028, 16'hffc4, 16'h04d2, 16'h7fff};
  logic [3:0]  tc [5] = '{4'h3, 4'h3, 4'h3, 4'h5, 4'h3};
  logic        tu [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

  aec_correct   aec_correct_inst (.*);
  aec_avg_model aec_avg_model_inst (.*);

  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic u, input logic [15:0] o, input logic [15:0] g);
    @(posedge ref_clk_i);
    #1;
    correct_unit_select_reg_i = u;
    offset_trim_value_i       = o;
    gain_trim_value_i         = g;
    correct_values_wr_i       = 1'b1;
    @(posedge ref_clk_i);
    #1;
    correct_values_wr_i = 1'b0;
  endtask : wr

  task automatic rd(input logic u, input logic [15:0] o, input logic [15:0] g);
    @(posedge ref_clk_i);
    #1;
    correct_unit_select_reg_i = u;
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk(offset_trim_value_o, o);
    chk(gain_trim_value_o, g);
  endtask : rd

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  initial
  begin
    #20000;
    error_cnt++;
    report_and_stop();
  end

  initial
  begin
    arst_n_i = 1'b0;
    res_ready_i = 1'b0;
    correct_values_wr_i = 1'b0;
    correct_unit_select_reg_i = 1'b0;
    channel_correct_enable_reg_i = 12'h000;
    offset_trim_value_i = 16'h0000;
    gain_trim_value_i = 16'h0000;
    repeat (4) @(posedge ref_clk_i);
    #1;
    arst_n_i = 1'b1;
    rd(1'b0, 16'h0000, 16'h4000);
    rd(1'b1, 16'h0000, 16'h4000);
    wr(1'b0, 16'h000a, 16'h8000);
    wr(1'b1, 16'hffec, 16'h4000);
    rd(1'b0, 16'h000a, 16'h8000);
    rd(1'b1, 16'hffec, 16'h4000);
    $display("test values done");
    channel_correct_enable_reg_i = 12'h008;
    // Sink stalls while the first beat waits in the output register and the rest queue up in the FIFO
    for (int i = 0; i < 5; i++)
      aec_avg_model_inst.send(td[i], tc[i], tu[i]);
    res_ready_i = 1'b1;
    n = 0;
    // Sampled off the edge; with ready high a shown beat leaves next edge
    repeat (40)
    begin
      if (res_valid_o === 1'b1 && n < 5)
      begin
        chk(res_data_o, te[n]);
        chk({12'h000, res_chan_o}, {12'h000, tc[n]});
        n++;
      end
      @(posedge ref_clk_i);
      #1;
    end
    chk(16'(n), 16'h0005);
    $display("test correction done");
    report_and_stop();
  end
endmodule : testbench
